// file: include/sf_cut_pkg.sv
// Constants and types for the tone trunk path-cut and filter timer
package sf_cut_pkg;

   // ---------------------------------------------------------------
   // Clock and tick
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS  = 40;
   localparam int TICK_PERIOD_US = 1000;
   localparam int TICK_CYCLES    = (TICK_PERIOD_US * 1000) / CLK_PERIOD_NS;

   // ---------------------------------------------------------------
   // Intervals in milliseconds (nominal, centre of tolerance)
   // ---------------------------------------------------------------
   localparam int TMR_W = 10;
   localparam logic [TMR_W-1:0] CUT_HOLD_MS  = 10'd625;
   localparam logic [TMR_W-1:0] CUT_ANS_MS   = 10'd125;
   localparam logic [TMR_W-1:0] FILT_HOLD_MS = 10'd50;
   localparam logic [TMR_W-1:0] FILT_MIN_MS  = 10'd225;
   localparam logic [TMR_W-1:0] PRECUT_MS    = 10'd12;
   localparam logic [TMR_W-1:0] TONE_QUAL_MS = 10'd13;
   localparam logic [TMR_W-1:0] TMR_ZERO     = 10'h000;

   // ---------------------------------------------------------------
   // Timer bank slots
   // ---------------------------------------------------------------
   localparam int NUM_TMR  = 5;
   localparam int TMR_CUT  = 0;
   localparam int TMR_FILT = 1;
   localparam int TMR_MINF = 2;
   localparam int TMR_MDLY = 3;
   localparam int TMR_QUAL = 4;

   // Call progress, one-hot
   typedef enum logic [3:0] {
      ST_IDLE     = 4'b0001,
      ST_SEIZED   = 4'b0010,
      ST_ANSWERED = 4'b0100,
      ST_DISC     = 4'b1000
   } call_state_t;

   // Controls toward the tone transceiver
   typedef struct packed {
      logic pathCut;    // Transmit path cut and terminated
      logic notchIn;    // receive_notch_filter in circuit
      logic mLeadBusy;  // Intermodule M lead, high stops outgoing tone
   } trunk_ctrl_t;

   localparam trunk_ctrl_t CTRL_RESET = '{pathCut: 1'b1, notchIn: 1'b1,
                                          mLeadBusy: 1'b0};

endpackage

// file: design/ms_tick_gen.sv
// Millisecond tick divider
`timescale 1ns/1ps
module ms_tick_gen #(
   parameter int TICK_CYCLES = 25000
) (
   input  wire logic clk_sys,
   input  wire logic rst_b,
   output logic      msTick
);
   localparam int CW = $clog2(TICK_CYCLES);
   localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);

   logic [CW-1:0] divCount;

   initial begin
      if (TICK_CYCLES < 2) begin
         $error("ms_tick_gen: TICK_CYCLES must be at least 2");
      end
   end

   // Free-running divider; one-cycle enable at each wrap
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         divCount <= '0;
         msTick   <= 1'b0;
      end else begin
         msTick   <= (divCount == LAST);
         divCount <= (divCount == LAST) ? '0 : divCount + 1'b1;
      end
   end
endmodule

// file: design/sf_path_cut_filter_timer.sv
// Transmit path cut, receive notch filter and M-lead delay timing
`timescale 1ns/1ps
module sf_path_cut_filter_timer
   import sf_cut_pkg::*;
#(
   parameter int TICK_CYCLES_P = TICK_CYCLES
) (
   input  wire logic  clk_sys,
   input  wire logic  rst_b,
   input  wire logic  toneRx,
   input  wire logic  mLeadLocal,
   output trunk_ctrl_t trunkCtrl
);

   // ---------------------------------------------------------------
   // Input synchronisers and edges
   // ---------------------------------------------------------------
   logic [1:0] toneSync;
   logic [1:0] mSync;
   logic       toneLast;
   logic       mLast;
   logic       msTick;

   // Both leads come from another module, so two flops before use
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         toneSync <= 2'b11;
         mSync    <= 2'b00;
         toneLast <= 1'b1;
         mLast    <= 1'b0;
      end else begin
         toneSync <= {toneSync[0], toneRx};
         mSync    <= {mSync[0], mLeadLocal};
         toneLast <= toneSync[1];
         mLast    <= mSync[1];
      end
   end

   wire toneNow  = toneSync[1];
   wire toneFall = toneLast & ~toneNow;   // Tone on to off
   wire toneRise = ~toneLast & toneNow;   // Tone off to on
   wire mRise    = ~mLast & mSync[1];     // Ground to battery
   wire mFall    = mLast & ~mSync[1];     // Battery to ground

   ms_tick_gen #(
      .TICK_CYCLES (TICK_CYCLES_P)
   ) u_tick (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .msTick  (msTick)
   );

   // ---------------------------------------------------------------
   // Millisecond timer bank
   // ---------------------------------------------------------------
   logic [TMR_W-1:0] tmr     [NUM_TMR];
   logic [TMR_W-1:0] tmrVal  [NUM_TMR];
   logic             tmrLoad [NUM_TMR];
   logic             tmrRun  [NUM_TMR];
   logic             tmrExp  [NUM_TMR];

   // Down counters stepped by the tick; a load restarts the interval
   // with up to one tick of phase error, well inside every tolerance
   for (genvar i = 0; i < NUM_TMR; i++) begin : g_tmr
      always_ff @(posedge clk_sys or negedge rst_b) begin
         if (!rst_b) begin
            tmr[i] <= TMR_ZERO;
         end else if (tmrLoad[i]) begin
            tmr[i] <= tmrVal[i];
         end else if (msTick && tmr[i] != TMR_ZERO) begin
            tmr[i] <= tmr[i] - 1'b1;
         end
      end
      assign tmrRun[i] = (tmr[i] != TMR_ZERO);
      assign tmrExp[i] = msTick & (tmr[i] == 10'd1) & ~tmrLoad[i];
   end

   // ---------------------------------------------------------------
   // Call state and flags
   // ---------------------------------------------------------------
   call_state_t state;
   call_state_t next_state;
   logic        startDialSeen;
   logic        pulseSeen;
   logic        pulseCut;
   logic        toneHeld;
   logic        mPrecut;
   logic        discCut;
   logic        mTx;

   wire isIdle     = (state == ST_IDLE);
   wire isSeized   = (state == ST_SEIZED);
   wire isAnswered = (state == ST_ANSWERED);
   wire isDisc     = (state == ST_DISC);
   wire toneQual   = tmrExp[TMR_QUAL];   // Tone held for 13 ms
   wire delayDone  = tmrExp[TMR_MDLY];
   wire pulsing    = isSeized & startDialSeen;
   wire ansEdge    = isSeized & startDialSeen & mRise;
   wire localDisc  = isAnswered & mFall;
   wire farDisc    = isAnswered & toneQual;
   wire backIdle   = isDisc & toneNow & ~mSync[1] & ~mPrecut;
   wire abandon    = isSeized & ~startDialSeen & toneQual & ~mSync[1];
   wire seize      = isIdle & toneFall;

   // Timer loads; the cut timer takes the longer hold on a clash
   wire cutLong  = toneFall & (isIdle | isSeized)
                 | delayDone & isSeized;
   // Reload at exactly 125 too, so a tick on the same edge cannot
   // leave less than the answer hold in the counter
   wire cutShort = mRise & ~isIdle & (tmr[TMR_CUT] <= CUT_ANS_MS);

   assign tmrLoad[TMR_CUT]  = cutLong | cutShort;
   assign tmrVal[TMR_CUT]   = cutLong ? CUT_HOLD_MS : CUT_ANS_MS;
   assign tmrLoad[TMR_FILT] = toneFall & (isIdle | isSeized);
   assign tmrVal[TMR_FILT]  = FILT_HOLD_MS;
   assign tmrLoad[TMR_MINF] = toneQual & pulsing & ~pulseSeen;
   assign tmrVal[TMR_MINF]  = FILT_MIN_MS;
   assign tmrLoad[TMR_MDLY] = mFall | mRise;
   assign tmrVal[TMR_MDLY]  = mFall ? PRECUT_MS : TMR_ZERO;
   assign tmrLoad[TMR_QUAL] = toneRise | toneFall;
   assign tmrVal[TMR_QUAL]  = toneRise ? TONE_QUAL_MS : TMR_ZERO;

   // Call progress
   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (seize) next_state = ST_SEIZED;
         end
         ST_SEIZED: begin
            if (ansEdge) next_state = ST_ANSWERED;
            else if (abandon) next_state = ST_IDLE;
         end
         ST_ANSWERED: begin
            if (localDisc | farDisc) next_state = ST_DISC;
         end
         ST_DISC: begin
            if (backIdle) next_state = ST_IDLE;
         end
         default: next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Call flags; cleared whenever the trunk falls back to idle
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         startDialSeen <= 1'b0;
         pulseSeen     <= 1'b0;
         discCut       <= 1'b0;
      end else if (next_state == ST_IDLE) begin
         startDialSeen <= 1'b0;
         pulseSeen     <= 1'b0;
         discCut       <= 1'b0;
      end else begin
         if (delayDone & isSeized) startDialSeen <= 1'b1;
         if (toneQual & pulsing) pulseSeen <= 1'b1;
         if (localDisc) discCut <= 1'b1;
      end
   end

   // Tone-driven holds: pulse cut and filter follow each pulse
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         pulseCut <= 1'b0;
         toneHeld <= 1'b0;
      end else if (toneFall) begin
         pulseCut <= 1'b0;   // hand over to the 625 ms hold
         toneHeld <= 1'b0;
      end else if (toneQual) begin
         pulseCut <= pulsing;
         toneHeld <= 1'b1;
      end
   end

   // M lead: busy passes at once, tone return waits out the precut
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         mTx     <= 1'b0;
         mPrecut <= 1'b0;
      end else if (mRise) begin
         mTx     <= 1'b1;
         mPrecut <= 1'b0;
      end else if (mFall) begin
         mPrecut <= 1'b1;
      end else if (delayDone) begin
         mTx     <= 1'b0;
         mPrecut <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   trunk_ctrl_t nextCtrl;

   // Idle cuts the path and inserts the filter; outside idle timers, holds and the local disconnect flag in ST_DISC do
   assign nextCtrl.pathCut   = isIdle | tmrRun[TMR_CUT] | pulseCut
                             | mPrecut | (isDisc & discCut);
   assign nextCtrl.notchIn   = isIdle | toneHeld | tmrRun[TMR_FILT]
                             | tmrRun[TMR_MINF];
   assign nextCtrl.mLeadBusy = mTx;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         trunkCtrl <= CTRL_RESET;
      end else begin
         trunkCtrl <= nextCtrl;
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   chk_seize_cut_hold: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      seize |=> (tmr[TMR_CUT] == CUT_HOLD_MS) && nextCtrl.pathCut)
      else $error("seizure did not start the long cut hold");

   chk_seize_filter: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      seize |=> tmr[TMR_FILT] == FILT_HOLD_MS && !isIdle)
      else $error("seizure did not start the filter hold");

   chk_answer_cut: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      (mRise && !isIdle) |=> tmr[TMR_CUT] >= CUT_ANS_MS)
      else $error("M lead busy did not cut the path");

   chk_precut_delay: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      (mFall && mTx) |=> mPrecut && mTx
         && tmr[TMR_MDLY] == PRECUT_MS)
      else $error("precut not applied before tone return");

   chk_pulse_cut: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      (toneQual && pulsing && !toneFall) |=> nextCtrl.pathCut ##1
         trunkCtrl.pathCut)
      else $error("incoming pulse did not cut the path");

   chk_pulse_hold: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      (toneFall && isSeized) |=> tmr[TMR_CUT] == CUT_HOLD_MS)
      else $error("pulse break did not restart the cut hold");

   chk_notch_insert: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      (toneQual && !toneFall) |=> ##1 trunkCtrl.notchIn)
      else $error("qualified tone did not insert the filter");

   chk_notch_minimum: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      tmrRun[TMR_MINF] |=> trunkCtrl.notchIn)
      else $error("filter removed before minimum hold");

   chk_far_disc: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      (farDisc && !tmrRun[TMR_CUT] && !mPrecut) |=> isDisc
         && !nextCtrl.pathCut && toneHeld)
      else $error("distant disconnect handled wrongly");

   chk_local_disc: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      localDisc |=> (isDisc && nextCtrl.pathCut) [*8])
      else $error("local disconnect did not hold the cut");

   chk_cut_before_tone: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      $fell(mTx) |-> $past(mPrecut) && nextCtrl.pathCut == $past(
         nextCtrl.pathCut))
      else $error("outgoing tone restored without a cut");

   chk_talk_quiet: assert property (
      @(posedge clk_sys) disable iff (!rst_b)
      (isAnswered && !tmrRun[TMR_CUT] && !tmrRun[TMR_FILT]
         && !tmrRun[TMR_MINF] && !toneHeld && !mPrecut && !pulseCut)
      |-> !nextCtrl.pathCut && !nextCtrl.notchIn)
      else $error("talking state not clear");

endmodule

// file: bench/sf_far_side_model.sv
// Far-side model: tone transceiver and local switch leads
`timescale 1ns/1ps
module sf_far_side_model
   import sf_cut_pkg::*;
#(
   parameter int MS = 4
) (
   input  wire logic         clk_sys,
   input  wire logic         rst_b,
   input  wire logic         toneCmd,
   input  wire logic         mCmd,
   input  wire trunk_ctrl_t  trunkCtrl,
   output logic              toneRx,
   output logic              mLeadLocal,
   output logic              txTone,
   output logic [7:0]        cutFaults
);
   logic txPrev;
   int   cutAge;

   // ---------------------------------------------------------------
   // Lead levels and outgoing tone
   // ---------------------------------------------------------------
   // Detector and switch present clean levels; no bounce is modelled
   assign toneRx     = toneCmd;
   assign mLeadLocal = mCmd;
   // Generator sends tone whenever the intermodule lead is idle
   assign txTone     = ~trunkCtrl.mLeadBusy;

   // ---------------------------------------------------------------
   // Precut watch
   // ---------------------------------------------------------------
   // Tone into an uncut path would leak signaling into the far end
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         txPrev    <= 1'h1;
         cutAge    <= 0;
         cutFaults <= 8'h00;
      end else begin
         txPrev <= txTone;
         cutAge <= trunkCtrl.pathCut ? cutAge + 1 : 0;
         if (txTone && !txPrev && cutAge < 7 * MS) begin
            cutFaults <= cutFaults + 8'h01;
         end
      end
   end
endmodule

// file: bench/testbench.sv
// Self-checking bench for the path-cut and notch filter timer
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fails++; \
   $display("BAD t=%0t got %h exp %h", $time, (a), (b)); end end
module testbench
   import sf_cut_pkg::*;
;
   localparam int MS    = 4;  // Cycles per tick, keeps the run short
   localparam int CUT   = 2;
   localparam int NOTCH = 1;
   localparam int BUSY  = 0;

   logic        clk_sys;
   logic        rst_b;
   logic        toneCmd;
   logic        mCmd;
   logic        toneRx;
   logic        mLeadLocal;
   logic        txTone;
   logic [7:0]  cutFaults;
   trunk_ctrl_t trunkCtrl;
   int          fails;
   int          check_count;
   int          c;
   int          c2;
   int          c3;

   // ---------------------------------------------------------------
   // Clock, design and far side
   // ---------------------------------------------------------------
   always #20 clk_sys = ~clk_sys;

   sf_path_cut_filter_timer #(.TICK_CYCLES_P(MS)) dut (
      .clk_sys    (clk_sys),
      .rst_b      (rst_b),
      .toneRx     (toneRx),
      .mLeadLocal (mLeadLocal),
      .trunkCtrl  (trunkCtrl)
   );

   sf_far_side_model #(.MS(MS)) farSide (
      .clk_sys    (clk_sys),
      .rst_b      (rst_b),
      .toneCmd    (toneCmd),
      .mCmd       (mCmd),
      .trunkCtrl  (trunkCtrl),
      .toneRx     (toneRx),
      .mLeadLocal (mLeadLocal),
      .txTone     (txTone),
      .cutFaults  (cutFaults)
   );

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   task automatic give_verdict();
      if (fails == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic holdCyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask

   // Bounded wait for one control bit; elapsed cycles come back
   task automatic waitFor(input int idx, input logic v, input int maxMs,
                          output int cyc);
      cyc = 0;
      while (trunkCtrl[idx] !== v && cyc < maxMs * MS) begin
         @(negedge clk_sys);
         cyc++;
      end
      if (trunkCtrl[idx] !== v) begin
         fails++;
         give_verdict();
      end
   endtask

   // Tick phase widens the low end by a tick; synchronisers add 8 cycles at each end
   function automatic logic inWin(input int cyc, input int lo, input int hi);
      return (cyc >= lo * MS - MS - 8) && (cyc <= hi * MS + 8);
   endfunction

   // Returns 1 if the bit ever left the level during the watch
   task automatic watch(input int idx, input logic v, input int ms,
                        output logic moved);
      moved = 1'h0;
      repeat (ms * MS) begin
         @(negedge clk_sys);
         if (trunkCtrl[idx] !== v) moved = 1'h1;
      end
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic seizeAndDelayDial();
      toneCmd = 1'h0;
      waitFor(NOTCH, 1'h0, 100, c);
      `CHK(inWin(c, 45, 55), 1'h1)
      `CHK(trunkCtrl.pathCut, 1'h1)
      waitFor(CUT, 1'h0, 900, c2);
      `CHK(inWin(c + c2, 500, 750), 1'h1)
      mCmd = 1'h1;
      waitFor(CUT, 1'h1, 5, c);
      waitFor(CUT, 1'h0, 300, c2);
      `CHK(inWin(c + c2, 75, 175), 1'h1)
      `CHK(trunkCtrl.mLeadBusy, 1'h1)
   endtask

   task automatic startDial();
      mCmd = 1'h0;
      waitFor(CUT, 1'h1, 5, c);
      `CHK(trunkCtrl.mLeadBusy, 1'h1)
      waitFor(BUSY, 1'h0, 30, c2);
      `CHK(inWin(c + c2, 7, 17), 1'h1)
      waitFor(CUT, 1'h0, 900, c3);
      `CHK(inWin(c + c2 + c3, 500, 750), 1'h1)
   endtask

   // Three 25 ms pulses: the 225 ms minimum outlasts the 50 ms hold
   task automatic dialPulses();
      toneCmd = 1'h1;
      waitFor(NOTCH, 1'h1, 30, c);
      `CHK(inWin(c, 6, 20), 1'h1)
      waitFor(CUT, 1'h1, 35, c2);
      `CHK(inWin(c + c2, 0, 35), 1'h1)
      holdCyc(25 * MS - c - c2);
      toneCmd = 1'h0;
      repeat (2) begin
         holdCyc(25 * MS);
         toneCmd = 1'h1;
         holdCyc(25 * MS);
         toneCmd = 1'h0;
      end
      `CHK(trunkCtrl.pathCut, 1'h1)
      waitFor(NOTCH, 1'h0, 300, c);
      `CHK(inWin(125 * MS + c, 175, 275), 1'h1)
      waitFor(CUT, 1'h0, 900, c2);
      `CHK(inWin(c + c2, 500, 750), 1'h1)
   endtask

   task automatic answerAndTalk();
      mCmd = 1'h1;
      waitFor(BUSY, 1'h1, 5, c);
      waitFor(CUT, 1'h1, 5, c2);
      waitFor(CUT, 1'h0, 300, c3);
      `CHK(inWin(c + c2 + c3, 75, 175), 1'h1)
      holdCyc(100 * MS);
      `CHK(trunkCtrl[2:1], 2'h0)
   endtask

   task automatic disconnects();
      logic moved;
      toneCmd = 1'h1;
      waitFor(NOTCH, 1'h1, 30, c);
      `CHK(inWin(c, 6, 20), 1'h1)
      watch(CUT, 1'h0, 200, moved);
      `CHK(moved, 1'h0)
      mCmd = 1'h0;
      waitFor(CUT, 1'h1, 5, c);
      waitFor(BUSY, 1'h0, 30, c2);
      `CHK(inWin(c + c2, 7, 17), 1'h1)
      watch(CUT, 1'h1, 1000, moved);
      `CHK(moved, 1'h0)
      `CHK(trunkCtrl, CTRL_RESET)
      `CHK(cutFaults, 8'h00)
   endtask

   // Second call cleared from the local side; only the far end
   // restoring tone brings the trunk back to idle from here
   task automatic localDisconnect();
      logic moved;
      toneCmd = 1'h0;
      holdCyc(30 * MS);
      mCmd = 1'h1;
      holdCyc(30 * MS);
      mCmd = 1'h0;
      holdCyc(30 * MS);
      mCmd = 1'h1;
      waitFor(BUSY, 1'h1, 5, c);
      holdCyc(700 * MS);
      `CHK(trunkCtrl[2:1], 2'h0)
      mCmd = 1'h0;
      waitFor(CUT, 1'h1, 5, c);
      waitFor(BUSY, 1'h0, 30, c2);
      `CHK(inWin(c + c2, 7, 17), 1'h1)
      watch(CUT, 1'h1, 100, moved);
      `CHK(moved, 1'h0)
      toneCmd = 1'h1;
      watch(CUT, 1'h1, 50, moved);
      `CHK(moved, 1'h0)
      `CHK(trunkCtrl, CTRL_RESET)
      `CHK(cutFaults, 8'h00)
   endtask

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      clk_sys     = 1'h0;
      rst_b       = 1'h0;
      toneCmd     = 1'h1;
      mCmd        = 1'h0;
      fails       = 0;
      check_count = 0;
      holdCyc(3);
      `CHK(trunkCtrl, CTRL_RESET)
      rst_b = 1'h1;
      holdCyc(20);
      seizeAndDelayDial();
      startDial();
      dialPulses();
      answerAndTalk();
      disconnects();
      localDisconnect();
      give_verdict();
   end
endmodule
